/* File: inc/tsm_pkg.sv */
// Shared constants and types of the serial temperature and supply monitor.
package tsm_pkg;

    // Configuration word and result sizes.
    localparam int CFG_BITS = 4;
    localparam int RESULT_W_DEF = 10;
    localparam logic [1:0] CFG_TAIL_LAST = 2'h2;

    // Register byte offsets on the register bus.
    localparam logic [7:0] ADDR_TEMP_CODE = 8'h00;
    localparam logic [7:0] ADDR_SUPPLY_CODE = 8'h04;
    localparam logic [7:0] ADDR_DIFF1V_CODE = 8'h08;
    localparam logic [7:0] ADDR_DIFFHALF_CODE = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // Values after reset. The temperature code stands for 25 degrees Celsius.
    localparam logic [9:0] RST_TEMP_CODE = 10'h26C;
    localparam logic [9:0] RST_OTHER_CODE = 10'h000;

    // Status register field positions.
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_ORDER_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;
    localparam int STAT_INIT_BIT = 4;
    localparam int STAT_SAMPLE_BIT = 5;
    localparam int STAT_DONE_LSB = 8;
    localparam int STAT_ABORT_LSB = 16;
    localparam int CNT_W = 8;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_TEMP = 2'b00,
        MODE_SUPPLY = 2'b01,
        MODE_DIFF_1V = 2'b10,
        MODE_DIFF_HALF = 2'b11
    } mode_t;

    localparam mode_t RST_PREV_MODE = MODE_SUPPLY;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_HUNT = 3'b001,
        S_CONFIG = 3'b010,
        S_WAIT_NULL = 3'b011,
        S_SAMPLE = 3'b100,
        S_MSB = 3'b101,
        S_LSB = 3'b110,
        S_FILL = 3'b111
    } state_t;

endpackage

/* File: rtl/monitor_axi_regs.sv */
// Register bus slave holding the per-mode converter codes and reading back status.
`timescale 1ns/1ps
module monitor_axi_regs #(
    parameter int ADDR_W = 8,
    parameter int RESULT_W = 10
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Write channels
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // Read channels
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Block side
    input wire logic [31:0] statusWord,
    output logic [3:0][RESULT_W-1:0] codes
);

    if (ADDR_W < 5 || RESULT_W > 16) begin : g_check
        $error("monitor_axi_regs: unsupported ADDR_W or RESULT_W");
    end

    function automatic logic [2:0] regSlot(input logic [ADDR_W-1:0] a);
        if (a == ADDR_W'(tsm_pkg::ADDR_TEMP_CODE)) return 3'h0;
        if (a == ADDR_W'(tsm_pkg::ADDR_SUPPLY_CODE)) return 3'h1;
        if (a == ADDR_W'(tsm_pkg::ADDR_DIFF1V_CODE)) return 3'h2;
        if (a == ADDR_W'(tsm_pkg::ADDR_DIFFHALF_CODE)) return 3'h3;
        if (a == ADDR_W'(tsm_pkg::ADDR_STATUS)) return 3'h4;
        return 3'h7;
    endfunction

    logic [RESULT_W-1:0] codeMem_q [4];
    logic [RESULT_W-1:0] codeMem_d [4];
    logic awFull_q, awFull_d, wFull_q, wFull_d;
    logic [ADDR_W-1:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic awReady_q, awReady_d, wReady_q, wReady_d;
    logic bValid_q, bValid_d, arReady_q, arReady_d, rValid_q, rValid_d;
    logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
    logic [31:0] rData_q, rData_d;

    always_comb begin
        logic [2:0] slot;
        slot = regSlot(awAddr_q);
        codeMem_d = codeMem_q;
        awFull_d = awFull_q;
        awAddr_d = awAddr_q;
        wFull_d = wFull_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bValid_d = bValid_q;
        bResp_d = bResp_q;
        if (awvalid && awReady_q) begin
            awFull_d = 1'b1;
            awAddr_d = awaddr;
        end
        if (wvalid && wReady_q) begin
            wFull_d = 1'b1;
            wData_d = wdata;
            wStrb_d = wstrb;
        end
        if (bValid_q && bready) begin
            bValid_d = 1'b0;
        end
        if (awFull_q && wFull_q && !bValid_q) begin
            awFull_d = 1'b0;
            wFull_d = 1'b0;
            bValid_d = 1'b1;
            bResp_d = (slot < 3'h4) ? tsm_pkg::RESP_OKAY : tsm_pkg::RESP_SLVERR;
            if (slot < 3'h4) begin
                for (int i = 0; i < RESULT_W; i++) begin
                    if (wStrb_q[i/8]) codeMem_d[slot[1:0]][i] = wData_q[i];
                end
            end
        end
        awReady_d = !awFull_d && !bValid_d;
        wReady_d = !wFull_d && !bValid_d;
    end

    always_comb begin
        logic [2:0] rSlot;
        rSlot = regSlot(araddr);
        rValid_d = rValid_q;
        rData_d = rData_q;
        rResp_d = rResp_q;
        if (rValid_q && rready) begin
            rValid_d = 1'b0;
        end
        if (arvalid && arReady_q) begin
            rValid_d = 1'b1;
            rResp_d = (rSlot == 3'h7) ? tsm_pkg::RESP_SLVERR : tsm_pkg::RESP_OKAY;
            if (rSlot < 3'h4) begin
                rData_d = 32'(codeMem_q[rSlot[1:0]]);
            end else if (rSlot == 3'h4) begin
                rData_d = statusWord;
            end else begin
                rData_d = 32'h0000_0000;
            end
        end
        arReady_d = !rValid_d;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            codeMem_q[0] <= RESULT_W'(tsm_pkg::RST_TEMP_CODE);
            for (int i = 1; i < 4; i++) codeMem_q[i] <= RESULT_W'(tsm_pkg::RST_OTHER_CODE);
            awFull_q <= 1'b0;
            awAddr_q <= '0;
            wFull_q <= 1'b0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            awReady_q <= 1'b0;
            wReady_q <= 1'b0;
            bValid_q <= 1'b0;
            bResp_q <= tsm_pkg::RESP_OKAY;
            arReady_q <= 1'b0;
            rValid_q <= 1'b0;
            rData_q <= 32'h0000_0000;
            rResp_q <= tsm_pkg::RESP_OKAY;
        end else begin
            codeMem_q <= codeMem_d;
            awFull_q <= awFull_d;
            awAddr_q <= awAddr_d;
            wFull_q <= wFull_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            awReady_q <= awReady_d;
            wReady_q <= wReady_d;
            bValid_q <= bValid_d;
            bResp_q <= bResp_d;
            arReady_q <= arReady_d;
            rValid_q <= rValid_d;
            rData_q <= rData_d;
            rResp_q <= rResp_d;
        end
    end

    assign awready = awReady_q;
    assign wready = wReady_q;
    assign bvalid = bValid_q;
    assign bresp = bResp_q;
    assign arready = arReady_q;
    assign rvalid = rValid_q;
    assign rdata = rData_q;
    assign rresp = rResp_q;
    always_comb begin
        for (int g = 0; g < 4; g++) codes[g] = codeMem_q[g];
    end

endmodule

/* File: rtl/temp_supply_monitor_serial.sv */
// Serial configuration and readout logic of the temperature and supply monitor.
`timescale 1ns/1ps
module temp_supply_monitor_serial #(
    parameter int RESULT_W = tsm_pkg::RESULT_W_DEF,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Serial link
    input wire logic csN,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    output logic doutOe,
    // Register bus write channels
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // Register bus read channels
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);

    if (RESULT_W < 2 || RESULT_W > 16) begin : g_check
        $error("temp_supply_monitor_serial: RESULT_W must be 2 to 16");
    end

    localparam int IDX_W = $clog2(RESULT_W);
    localparam logic [IDX_W-1:0] IDX_TOP = IDX_W'(RESULT_W - 1);
    localparam logic [IDX_W-1:0] IDX_ZERO = '0;

    logic [3:0][RESULT_W-1:0] codes;
    logic [31:0] status_q, status_d;

    monitor_axi_regs #(
        .ADDR_W(ADDR_W),
        .RESULT_W(RESULT_W)
    ) u_regs (
        .mclk(mclk),
        .srst(srst),
        .awvalid(awvalid),
        .awready(awready),
        .awaddr(awaddr),
        .wvalid(wvalid),
        .wready(wready),
        .wdata(wdata),
        .wstrb(wstrb),
        .bvalid(bvalid),
        .bready(bready),
        .bresp(bresp),
        .arvalid(arvalid),
        .arready(arready),
        .araddr(araddr),
        .rvalid(rvalid),
        .rready(rready),
        .rdata(rdata),
        .rresp(rresp),
        .statusWord(status_q),
        .codes(codes)
    );

    // Pin history for edge detection; pins are synchronous to mclk.
    logic sclkPrev_q, csPrev_q;
    logic sclkRise, sclkFall, csFall, csRise;

    assign sclkRise = !csN && sclk && !sclkPrev_q;
    assign sclkFall = !csN && !sclk && sclkPrev_q;
    assign csFall = csPrev_q && !csN;
    assign csRise = !csPrev_q && csN;

    always_ff @(posedge mclk) begin
        if (srst) begin
            sclkPrev_q <= 1'b0;
            csPrev_q <= 1'b1;
        end else begin
            sclkPrev_q <= sclk;
            csPrev_q <= csN;
        end
    end

    // Exchange sequencer.
    tsm_pkg::state_t state_q, state_d;
    logic [1:0] cfg_q, cfg_d;
    logic [1:0] cfgCnt_q, cfgCnt_d;
    logic [IDX_W-1:0] idx_q, idx_d;
    logic [RESULT_W-1:0] result_q, result_d;
    logic dout_q, dout_d, doutOe_q, doutOe_d, sample_q, sample_d;
    logic msbOrderFlag_q, msbOrderFlag_d, initHint_q, initHint_d;
    tsm_pkg::mode_t mode_q, mode_d, prevMode_q, prevMode_d;
    logic [tsm_pkg::CNT_W-1:0] doneCnt_q, doneCnt_d, abortCnt_q, abortCnt_d;
    logic [RESULT_W-1:0] codeSel;

    // Every mode code passes unchanged; the temperature code is already
    // unipolar and linear in temperature, so no scaling happens here.
    assign codeSel = codes[mode_q];

    always_comb begin
        state_d = state_q;
        cfg_d = cfg_q;
        cfgCnt_d = cfgCnt_q;
        idx_d = idx_q;
        result_d = result_q;
        dout_d = dout_q;
        doutOe_d = doutOe_q;
        sample_d = sample_q;
        msbOrderFlag_d = msbOrderFlag_q;
        mode_d = mode_q;
        prevMode_d = prevMode_q;
        initHint_d = initHint_q;
        doneCnt_d = doneCnt_q;
        abortCnt_d = abortCnt_q;
        if (csN) begin
            // Select high wins over everything in flight.
            if (csRise && (state_q == tsm_pkg::S_WAIT_NULL || state_q == tsm_pkg::S_SAMPLE
                    || state_q == tsm_pkg::S_MSB)) begin
                abortCnt_d = abortCnt_q + 1'b1;
            end
            state_d = tsm_pkg::S_IDLE;
            doutOe_d = 1'b0;
            sample_d = 1'b0;
        end else begin
            unique case (state_q)
                tsm_pkg::S_IDLE: begin
                    if (csFall) begin
                        state_d = tsm_pkg::S_HUNT;
                    end
                end
                tsm_pkg::S_HUNT: begin
                    if (sclkRise && din) begin
                        state_d = tsm_pkg::S_CONFIG;
                        cfgCnt_d = 2'h0;
                    end
                end
                tsm_pkg::S_CONFIG: begin
                    if (sclkRise) begin
                        cfg_d = {cfg_q[0], din};
                        cfgCnt_d = cfgCnt_q + 1'b1;
                        if (cfgCnt_q == tsm_pkg::CFG_TAIL_LAST) begin
                            mode_d = tsm_pkg::mode_t'(cfg_q);
                            msbOrderFlag_d = din;
                            state_d = tsm_pkg::S_WAIT_NULL;
                            sample_d = 1'b1;
                            initHint_d = (tsm_pkg::mode_t'(cfg_q) == tsm_pkg::MODE_TEMP)
                                && (prevMode_q != tsm_pkg::MODE_TEMP);
                            prevMode_d = tsm_pkg::mode_t'(cfg_q);
                        end
                    end
                end
                tsm_pkg::S_WAIT_NULL: begin
                    if (sclkFall) begin
                        doutOe_d = 1'b1;
                        dout_d = 1'b0;
                        state_d = tsm_pkg::S_SAMPLE;
                    end
                end
                tsm_pkg::S_SAMPLE: begin
                    // The code is taken as the sampling window closes.
                    if (sclkFall) begin
                        result_d = codeSel;
                        sample_d = 1'b0;
                        dout_d = codeSel[RESULT_W-1];
                        idx_d = IDX_TOP - 1'b1;
                        state_d = tsm_pkg::S_MSB;
                    end
                end
                tsm_pkg::S_MSB: begin
                    if (sclkFall) begin
                        dout_d = result_q[idx_q];
                        if (idx_q == IDX_ZERO) begin
                            doneCnt_d = doneCnt_q + 1'b1;
                            state_d = msbOrderFlag_q ? tsm_pkg::S_FILL : tsm_pkg::S_LSB;
                        end else begin
                            idx_d = idx_q - 1'b1;
                        end
                    end
                end
                tsm_pkg::S_LSB: begin
                    if (sclkFall) begin
                        dout_d = result_q[idx_q];
                        if (idx_q == IDX_TOP) begin
                            state_d = tsm_pkg::S_FILL;
                        end else begin
                            idx_d = idx_q + 1'b1;
                        end
                    end
                end
                tsm_pkg::S_FILL: begin
                    if (sclkFall) begin
                        dout_d = 1'b0;
                    end
                end
            endcase
        end
        status_d = 32'h0000_0000;
        status_d[tsm_pkg::STAT_MODE_LSB +: 2] = mode_q;
        status_d[tsm_pkg::STAT_ORDER_BIT] = msbOrderFlag_q;
        status_d[tsm_pkg::STAT_BUSY_BIT] = (state_q != tsm_pkg::S_IDLE);
        status_d[tsm_pkg::STAT_INIT_BIT] = initHint_q;
        status_d[tsm_pkg::STAT_SAMPLE_BIT] = sample_q;
        status_d[tsm_pkg::STAT_DONE_LSB +: tsm_pkg::CNT_W] = doneCnt_q;
        status_d[tsm_pkg::STAT_ABORT_LSB +: tsm_pkg::CNT_W] = abortCnt_q;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= tsm_pkg::S_IDLE;
            cfg_q <= 2'h0;
            cfgCnt_q <= 2'h0;
            idx_q <= '0;
            result_q <= '0;
            dout_q <= 1'b0;
            doutOe_q <= 1'b0;
            sample_q <= 1'b0;
            msbOrderFlag_q <= 1'b0;
            mode_q <= tsm_pkg::MODE_TEMP;
            prevMode_q <= tsm_pkg::RST_PREV_MODE;
            initHint_q <= 1'b0;
            doneCnt_q <= '0;
            abortCnt_q <= '0;
            status_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            cfg_q <= cfg_d;
            cfgCnt_q <= cfgCnt_d;
            idx_q <= idx_d;
            result_q <= result_d;
            dout_q <= dout_d;
            doutOe_q <= doutOe_d;
            sample_q <= sample_d;
            msbOrderFlag_q <= msbOrderFlag_d;
            mode_q <= mode_d;
            prevMode_q <= prevMode_d;
            initHint_q <= initHint_d;
            doneCnt_q <= doneCnt_d;
            abortCnt_q <= abortCnt_d;
            status_q <= status_d;
        end
    end

    assign dout = dout_q;
    assign doutOe = doutOe_q;

    // Checks on the serial side.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence cfgDone_s;
        state_q == tsm_pkg::S_CONFIG && sclkRise && cfgCnt_q == tsm_pkg::CFG_TAIL_LAST;
    endsequence

    sequence nullOut_s;
        state_q == tsm_pkg::S_WAIT_NULL && sclkFall;
    endsequence

    sequence sampleEnd_s;
        state_q == tsm_pkg::S_SAMPLE && sclkFall;
    endsequence

    select_float_a: assert property (csN |=> !doutOe_q)
        else $error("Serial output driven while select is high");

    select_start_a: assert property (state_q == tsm_pkg::S_IDLE && csFall
            |=> state_q == tsm_pkg::S_HUNT)
        else $error("Falling select did not start an exchange");

    start_bit_a: assert property (state_q == tsm_pkg::S_HUNT && sclkRise && din
            |=> state_q == tsm_pkg::S_CONFIG && cfgCnt_q == 2'h0)
        else $error("Start bit not taken");

    zero_ignore_a: assert property (state_q == tsm_pkg::S_HUNT && !(sclkRise && din) && !csN
            |=> state_q == tsm_pkg::S_HUNT)
        else $error("Leading zero left the hunt");

    config_done_a: assert property (cfgDone_s |=> state_q == tsm_pkg::S_WAIT_NULL
            && sample_q && !doutOe_q && msbOrderFlag_q == $past(din))
        else $error("Configuration word not closed correctly");

    config_hold_a: assert property (state_q inside {tsm_pkg::S_MSB, tsm_pkg::S_LSB,
            tsm_pkg::S_FILL} |=> $stable(mode_q) && $stable(msbOrderFlag_q))
        else $error("Configuration changed after the word");

    null_bit_a: assert property (nullOut_s and (!csN) |=> doutOe_q && !dout_q)
        else $error("Null bit not driven after the word");

    sample_window_a: assert property (sampleEnd_s |-> sample_q && $past(sample_q))
        else $error("Sampling window closed early");

    msb_first_a: assert property (sampleEnd_s and (!csN) |=> state_q == tsm_pkg::S_MSB
            && !sample_q && dout_q == $past(codeSel[RESULT_W-1]))
        else $error("Result MSB not sent at end of sampling");

    fall_only_a: assert property ($changed(dout_q) |-> $past(sclkFall))
        else $error("Serial output changed without a falling clock");

    fill_zero_a: assert property (state_q == tsm_pkg::S_FILL && sclkFall && !csN
            |=> !dout_q && doutOe_q)
        else $error("Fill bit is not zero");

    lsb_echo_a: assert property (state_q == tsm_pkg::S_LSB && sclkFall && !csN
            |=> dout_q == $past(result_q[idx_q]))
        else $error("LSB-first echo bit wrong");

    idle_return_a: assert property (csN && state_q != tsm_pkg::S_IDLE
            |=> state_q == tsm_pkg::S_IDLE ##1 !doutOe_q)
        else $error("Raised select did not return to idle");

endmodule

/* File: tb/serial_host_model.sv */
// Host side of the serial link: drives select, shift clock and data, captures the reply.
`timescale 1ns/1ps
module serial_host_model (
    // Clock
    input wire logic mclk,
    // From the monitor
    input wire logic dout,
    input wire logic doutOe,
    // To the monitor
    output logic csN,
    output logic sclk,
    output logic din
);
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end

    task automatic xfer(input logic [1:0] mode, input logic flag, input int lead, input int n,
                        output logic [31:0] got, output logic early);
        logic [3:0] w;
        int i;
        w = {1'b1, mode, flag};
        got = 32'h0;
        early = 1'b0;
        // Clock pulses with din high while deselected must be ignored.
        for (i = 0; i < 4; i++) begin
            @(posedge mclk);
            sclk <= ~sclk;
            din <= 1'b1;
        end
        @(posedge mclk);
        csN <= 1'b0;
        repeat ((mode == 2'h0) ? 4000 : 500) @(posedge mclk);
        for (i = 0; i < lead + 4 + n; i++) begin
            sclk <= 1'b0;
            din <= (i < lead) ? 1'b0 : (i < lead + 4) ? w[lead + 3 - i] : i[0];
            repeat (4) @(posedge mclk);
            sclk <= 1'b1;
            @(posedge mclk);
            if (i < lead + 4 && doutOe) early = 1'b1;
            // An undriven line is seen as the inverse of the last level.
            if (i >= lead + 4) got = {got[30:0], doutOe ? dout : ~dout};
            repeat (3) @(posedge mclk);
        end
        sclk <= 1'b0;
        repeat (4) @(posedge mclk);
        csN <= 1'b1;
        // A released line does not keep its last level.
        din <= ~din;
    endtask
endmodule

/* File: tb/temp_supply_monitor_serial_tb.sv */
// Self-checking bench of the monitor: register bus tasks plus serial transfers.
`timescale 1ns/1ps
module temp_supply_monitor_serial_tb;
    logic mclk, srst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, dout, doutOe, csN, sclk, din, early;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, got, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic [9:0] code [4];
    int n_fail, checked, m, f;

    temp_supply_monitor_serial dut (.mclk(mclk), .srst(srst), .csN(csN), .sclk(sclk),
        .din(din), .dout(dout), .doutOe(doutOe), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp));

    serial_host_model host (.mclk(mclk), .dout(dout), .doutOe(doutOe), .csN(csN),
        .sclk(sclk), .din(din));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Null bit, result MSB first, then either zeros or the LSB-first echo.
    function automatic logic [31:0] frame(input logic [9:0] c, input logic fl);
        logic [9:0] rv;
        for (int k = 0; k < 10; k++) rv[k] = c[9 - k];
        return {11'h000, 1'b0, c, fl ? 10'h000 : rv};
    endfunction

    task automatic final_report;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #800_000;
        n_fail++;
        final_report;
    end

    initial begin
        {srst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata, wstrb} = 52'h0000000000000F;
        n_fail = 0;
        checked = 0;
        code = '{10'h26C, 10'h222, 10'h3FF, 10'h001};
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        repeat (2) @(posedge mclk);
        axr(tsm_pkg::ADDR_TEMP_CODE, rd, rsp);
        chk(rd, 32'h0000026C);
        axr(8'h14, rd, rsp);
        chk({30'h0, rsp}, {30'h0, tsm_pkg::RESP_SLVERR});
        for (m = 1; m < 4; m++) begin
            axw({m[5:0], 2'b00}, {22'h0, code[m]}, rsp);
            chk({30'h0, rsp}, {30'h0, tsm_pkg::RESP_OKAY});
        end
        axw(tsm_pkg::ADDR_STATUS, 32'hFFFFFFFF, rsp);
        chk({30'h0, rsp}, {30'h0, tsm_pkg::RESP_SLVERR});
        host.xfer(2'h0, 1'b1, 0, 21, got, early);
        axr(tsm_pkg::ADDR_STATUS, rd, rsp);
        chk({27'h0, rd[5:4], rd[2:0]}, 32'h0000000C);
        for (m = 0; m < 4; m++) begin
            for (f = 0; f < 2; f++) begin
                host.xfer(m[1:0], f[0], m, 21, got, early);
                chk(got, frame(code[m], f[0]));
                chk({31'h0, early}, 32'h0);
            end
        end
        host.xfer(2'h1, 1'b1, 0, 3, got, early);
        chk(got, {29'h0, 1'b0, code[1][9:8]});
        repeat (2) @(posedge mclk);
        chk({31'h0, doutOe}, 32'h0);
        host.xfer(2'h2, 1'b1, 1, 21, got, early);
        chk(got, frame(code[2], 1'b1));
        axr(tsm_pkg::ADDR_STATUS, rd, rsp);
        chk({16'h0, rd[23:16], rd[15:8]}, 32'h0000010A);
        chk({29'h0, rd[2:0]}, 32'h00000006);
        final_report;
    end
endmodule
